// ==== include/psb_pkg.sv ====
// Package for the PHY status, bypass control and error counter register group.
// Assumes a 5-bit register address and 16-bit register data from the management port.
package psb_pkg;

  // Register addresses of the group.
  localparam logic [4:0] PSB_ADDR_STATUS = 5'h11;
  localparam logic [4:0] PSB_ADDR_BYPASS = 5'h12;
  localparam logic [4:0] PSB_ADDR_RXERR  = 5'h13;
  localparam logic [4:0] PSB_ADDR_FCAR   = 5'h14;
  localparam logic [4:0] PSB_ADDR_LDROP  = 5'h15;

  // Status register bit positions.
  localparam int PSB_ST_LOCKED  = 15;
  localparam int PSB_ST_LINK    = 12;
  localparam int PSB_ST_LEGACY  = 6;
  localparam int PSB_ST_XOVER   = 5;
  // Self-clearing status flags: bits 14, 13 and 11 down to 7.
  localparam logic [15:0] PSB_ST_SC_MASK = 16'h6F80;

  // Bypass register bit positions.
  localparam int PSB_BY_TXDIS   = 15;
  localparam int PSB_BY_4B5B    = 14;
  localparam int PSB_BY_SCR     = 13;
  localparam int PSB_BY_DESCR   = 12;
  localparam int PSB_BY_PCSRX   = 11;
  localparam int PSB_BY_PCSTX   = 10;
  localparam int PSB_BY_LFI     = 9;
  localparam int PSB_BY_AUTOMDI = 7;
  localparam int PSB_BY_LEGDIS  = 6;
  localparam int PSB_BY_PAIRSW  = 5;
  localparam int PSB_BY_POLCOR  = 4;
  localparam int PSB_BY_PARDET  = 3;
  localparam int PSB_BY_PULSE   = 2;
  localparam int PSB_BY_NPDIS   = 1;
  localparam int PSB_BY_CLOCK_OUTPUT_PIN  = 0;
  // Writable bits (bit 8 is reserved and reads zero).
  localparam logic [15:0] PSB_BY_WR_MASK     = 16'hFEFF;
  // Sticky bits: 7, 6, 5, 4, 3, 1 and 0.
  localparam logic [15:0] PSB_BY_STICKY_MASK = 16'h00FB;
  // Reset value without the strap-driven bit 0.
  localparam logic [15:0] PSB_BY_RESET       = 16'h0088;

  // Counter width, saturation value and reset value.
  localparam int          PSB_CNT_W   = 8;
  localparam logic [7:0]  PSB_CNT_MAX = 8'hFF;
  localparam logic [7:0]  PSB_CNT_RST = 8'h00;
  localparam int          PSB_NUM_CNT = 3;

  // Event and level inputs from the transceiver datapath.
  typedef struct packed {
    logic descr_locked;   // Gigabit descrambler locked (level).
    logic link_up;        // Gigabit link active (level).
    logic legacy_lp;      // Non-compliant legacy partner seen (level).
    logic xover_err;      // Crossover error seen (level).
    logic lock_err;       // Lock error (pulse).
    logic disconnect;     // Gigabit link disconnect (pulse).
    logic gb_rx_err;      // Gigabit receive error (pulse).
    logic gb_tx_err;      // Gigabit transmit error (pulse).
    logic ssd_err;        // Stream start delimiter error (pulse).
    logic esd_err;        // Stream end delimiter error (pulse).
    logic ext_err;        // Carrier extension error (pulse).
    logic rx_err_ev;      // 100/1000 receive error to count (pulse).
    logic false_car_ev;   // False carrier to count (pulse).
    logic link_drop_ev;   // Copper link drop to count (pulse).
  } psb_events_s;

  // Controls that steer the datapath.
  typedef struct packed {
    logic tx_disable;
    logic bypass_4b5b;
    logic bypass_scrambler;
    logic bypass_descrambler;
    logic bypass_pcs_rx;
    logic bypass_pcs_tx;
    logic skip_link_fail_inhibit_timer;
    logic auto_mdix_off_forced;
    logic legacy_detect_off;
    logic pair_swap_off;
    logic polarity_corr_off;
    logic parallel_detect_honour;
    logic pulse_shaping_off;
    logic next_page_manual;
    logic clock_output_pin_en;
  } psb_ctrl_s;

endpackage

// ==== rtl/psb_regs.sv ====
// Status, bypass control and error counter registers of a gigabit copper transceiver.
// Assumes a register port on clk_i, datapath events on clk_i and a strap from a pin.
//
// Overview of operation
// - Bit 15 shows descrambler lock.
// - Error events set self-clearing status flags.
// - Bit 12 shows gigabit link active.
// - Bits 6 and 5 show legacy partner, crossover.
// - Bypass bit 15 disables transmitter, resets zero.
// - Bypass bit 14 skips 4B/5B coding.
// - Bits 13 and 12 skip scrambler, descrambler.
// - Bits 11 and 10 skip PCS receive, transmit.
// - Bit 9 skips link fail inhibit timer.
// - Sticky bit 7 stops auto crossover, resets one.
// - Sticky bits 5, 4 stop swap, polarity correction.
// - Sticky bit 3 honours advertised ability; resets one.
// - Bit 2 disables pulse shaping filter.
// - Sticky bit 1 hands next pages to software.
// - Sticky bit 0 enables clock output; strap default.
// - Counters are eight bits, start zero, saturate.
// - Reading a counter returns it and clears it.
// - Counters count receive errors and false carriers.
// - Third counter counts link drops; upper bits zero.
// - Sticky bits survive software reset when enabled.
`timescale 1ns/100ps
module psb_regs (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [4:0]            reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [15:0]           reg_wdata_i,
  output logic [15:0]                reg_rdata_o,
  output logic                       reg_rvalid_o,
  output logic                       reg_hit_o,
  input  wire logic                  soft_reset_i,
  input  wire logic                  sticky_reset_en_i,
  input  wire logic                  config_strap_pins_i,
  input  wire psb_pkg::psb_events_s  events_i,
  output psb_pkg::psb_ctrl_s         ctrl_o
);
  import psb_pkg::*;

  // Returns one when the access addresses the given register.
  function automatic logic addr_is(input logic [4:0] a, input logic [4:0] r);
    addr_is = (a == r);
  endfunction

  logic [15:0]          st_sc_q;       // Self-clearing status flags.
  logic [15:0]          st_word;       // Status word as read.
  logic [15:0]          byp_q;         // Bypass and feature control bits.
  logic [15:0]          byp_default;   // Default bypass value with strap bit.
  logic                 strap_s1_q;    // Strap synchroniser, first stage.
  logic                 strap_s2_q;    // Strap synchroniser, second stage.
  logic                 strap_q;       // Strap level caught after reset.
  logic                 strap_done_q;  // Strap has been caught.
  logic                 rd_status;     // Read of the status register.
  logic                 wr_bypass;     // Write of the bypass register.
  logic [15:0]          sc_set;        // Flags raised this cycle.
  logic [PSB_NUM_CNT-1:0]             cnt_inc;  // Counter event pulses.
  logic [PSB_NUM_CNT-1:0]             cnt_clr;  // Counter clearing reads.
  logic [PSB_NUM_CNT-1:0][PSB_CNT_W-1:0] cnt_val; // Counter values.
  logic [15:0]          rd_mux;        // Combinational read data.

  // Access decodes.
  assign rd_status = reg_rd_i && addr_is(reg_addr_i, PSB_ADDR_STATUS);
  assign wr_bypass = reg_wr_i && addr_is(reg_addr_i, PSB_ADDR_BYPASS);

  // Strap pin passes two flip-flops before use. The pair has no reset, so it keeps
  // sampling through reset and holds a settled strap level when reset lifts.
  always_ff @(posedge clk_i) begin
    strap_s1_q <= config_strap_pins_i;
    strap_s2_q <= strap_s1_q;
  end

  // Catches the synchronised strap once, after reset release.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q      <= strap_s2_q;
      strap_done_q <= 1'b1;
    end
  end

  // Default value, with the clock output enable taken from the strap.
  assign byp_default = PSB_BY_RESET | {15'h0000, strap_q};

  // Bypass register: write, software reset and strap load.
  // Software reset takes priority over a write in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byp_q <= PSB_BY_RESET;
    end else if (strap_done_q == 1'b0) begin
      byp_q <= PSB_BY_RESET | {15'h0000, strap_s2_q};
    end else if (soft_reset_i) begin
      // Sticky bits keep their value only while the enable is set.
      if (sticky_reset_en_i) begin
        byp_q <= (byp_q & PSB_BY_STICKY_MASK) | (byp_default & ~PSB_BY_STICKY_MASK);
      end else begin
        byp_q <= byp_default;
      end
    end else if (wr_bypass) begin
      byp_q <= reg_wdata_i & PSB_BY_WR_MASK;
    end
  end

  // Control outputs come straight from the bypass flip-flops.
  always_comb begin
    ctrl_o.tx_disable                   = byp_q[PSB_BY_TXDIS];
    ctrl_o.bypass_4b5b                  = byp_q[PSB_BY_4B5B];
    ctrl_o.bypass_scrambler             = byp_q[PSB_BY_SCR];
    ctrl_o.bypass_descrambler           = byp_q[PSB_BY_DESCR];
    ctrl_o.bypass_pcs_rx                = byp_q[PSB_BY_PCSRX];
    ctrl_o.bypass_pcs_tx                = byp_q[PSB_BY_PCSTX];
    ctrl_o.skip_link_fail_inhibit_timer = byp_q[PSB_BY_LFI];
    ctrl_o.auto_mdix_off_forced         = byp_q[PSB_BY_AUTOMDI];
    ctrl_o.legacy_detect_off            = byp_q[PSB_BY_LEGDIS];
    ctrl_o.pair_swap_off                = byp_q[PSB_BY_PAIRSW];
    ctrl_o.polarity_corr_off            = byp_q[PSB_BY_POLCOR];
    ctrl_o.parallel_detect_honour       = byp_q[PSB_BY_PARDET];
    ctrl_o.pulse_shaping_off            = byp_q[PSB_BY_PULSE];
    // Manual mode leaves next pages to the host after the base page.
    ctrl_o.next_page_manual             = byp_q[PSB_BY_NPDIS];
    ctrl_o.clock_output_pin_en          = byp_q[PSB_BY_CLOCK_OUTPUT_PIN];
  end

  // Flags raised by datapath events this cycle.
  always_comb begin
    sc_set     = 16'h0000;
    sc_set[14] = events_i.lock_err;
    sc_set[13] = events_i.disconnect;
    sc_set[11] = events_i.gb_rx_err;
    sc_set[10] = events_i.gb_tx_err;
    sc_set[9]  = events_i.ssd_err;
    sc_set[8]  = events_i.esd_err;
    sc_set[7]  = events_i.ext_err;
  end

  // Self-clearing flags: a read clears them, a new event wins over the clear.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_sc_q <= 16'h0000;
    end else if (soft_reset_i) begin
      st_sc_q <= sc_set;
    end else if (rd_status) begin
      st_sc_q <= sc_set;
    end else begin
      st_sc_q <= st_sc_q | sc_set;
    end
  end

  // Status word: live levels plus latched flags.
  always_comb begin
    st_word                = st_sc_q & PSB_ST_SC_MASK;
    st_word[PSB_ST_LOCKED] = events_i.descr_locked;
    st_word[PSB_ST_LINK]   = events_i.link_up;
    // Legacy detection is blocked while its disable bit is set.
    st_word[PSB_ST_LEGACY] = events_i.legacy_lp && !byp_q[PSB_BY_LEGDIS];
    st_word[PSB_ST_XOVER]  = events_i.xover_err;
  end

  // Counter events and clearing reads.
  assign cnt_inc = {events_i.link_drop_ev, events_i.false_car_ev, events_i.rx_err_ev};
  assign cnt_clr[0] = reg_rd_i && addr_is(reg_addr_i, PSB_ADDR_RXERR);
  assign cnt_clr[1] = reg_rd_i && addr_is(reg_addr_i, PSB_ADDR_FCAR);
  assign cnt_clr[2] = reg_rd_i && addr_is(reg_addr_i, PSB_ADDR_LDROP);

  // One saturating counter per error source.
  genvar gi;
  generate
    for (gi = 0; gi < PSB_NUM_CNT; gi++) begin : g_cnt
      psb_sat_counter u_cnt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .inc_i   (cnt_inc[gi]),
        .clr_i   (cnt_clr[gi]),
        .count_o (cnt_val[gi])
      );
    end
  endgenerate

  // Read data selection; unmapped addresses read zero.
  always_comb begin
    if (addr_is(reg_addr_i, PSB_ADDR_STATUS)) begin
      rd_mux = st_word;
    end else if (addr_is(reg_addr_i, PSB_ADDR_BYPASS)) begin
      rd_mux = byp_q;
    end else if (addr_is(reg_addr_i, PSB_ADDR_RXERR)) begin
      rd_mux = {8'h00, cnt_val[0]};
    end else if (addr_is(reg_addr_i, PSB_ADDR_FCAR)) begin
      rd_mux = {8'h00, cnt_val[1]};
    end else if (addr_is(reg_addr_i, PSB_ADDR_LDROP)) begin
      rd_mux = {8'h00, cnt_val[2]};
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // Hit flag tells the management port this group owns the address.
  assign reg_hit_o = (reg_addr_i >= PSB_ADDR_STATUS) && (reg_addr_i <= PSB_ADDR_LDROP);

  // Read data is registered and held until the next read.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // Read valid pulses one cycle after each read strobe.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // A status read followed by its data.
  sequence s_status_read;
    reg_rd_i && addr_is(reg_addr_i, PSB_ADDR_STATUS);
  endsequence

  // A receive counter read followed by its data.
  sequence s_rxcnt_read;
    cnt_clr[0] && !soft_reset_i;
  endsequence

  lock_bit_a: assert property (s_status_read |=>
    reg_rdata_o[PSB_ST_LOCKED] == $past(events_i.descr_locked))
    else $error("Lock bit does not follow descrambler lock.");

  sc_set_a: assert property (events_i.lock_err |=> st_sc_q[14])
    else $error("Lock error flag not set by event.");

  sc_clear_a: assert property ((s_status_read and (sc_set == 16'h0000) and
    !soft_reset_i) |=> (st_sc_q == 16'h0000) ##1 1'b1)
    else $error("Self-clearing flags not cleared by read.");

  link_bit_a: assert property (s_status_read |=>
    reg_rdata_o[PSB_ST_LINK] == $past(events_i.link_up))
    else $error("Link bit does not follow link state.");

  legacy_bit_a: assert property ((s_status_read and byp_q[PSB_BY_LEGDIS]) |=>
    !reg_rdata_o[PSB_ST_LEGACY])
    else $error("Legacy partner shown while detection is off.");

  txdis_out_a: assert property ((wr_bypass && !soft_reset_i && strap_done_q) |=>
    ctrl_o.tx_disable == $past(reg_wdata_i[PSB_BY_TXDIS]))
    else $error("Transmit disable does not follow the write.");

  cnt_sat_a: assert property ((cnt_val[0] == PSB_CNT_MAX) && !cnt_clr[0] |=>
    cnt_val[0] == PSB_CNT_MAX)
    else $error("Receive error counter left saturation.");

  cnt_clr_a: assert property ((cnt_clr[1] && !cnt_inc[1]) |=>
    (cnt_val[1] == PSB_CNT_RST))
    else $error("False carrier counter not cleared by its read.");

  cnt_read_a: assert property (s_rxcnt_read |=>
    (reg_rdata_o == {8'h00, $past(cnt_val[0])}) &&
    (cnt_val[0] == {7'h00, $past(cnt_inc[0])}))
    else $error("Counter read did not return and clear the count.");

  sticky_keep_a: assert property ((soft_reset_i && sticky_reset_en_i && strap_done_q) |=>
    ((byp_q & PSB_BY_STICKY_MASK) == ($past(byp_q) & PSB_BY_STICKY_MASK)))
    else $error("Sticky bits lost on software reset.");

  sticky_def_a: assert property ((soft_reset_i && !sticky_reset_en_i && strap_done_q) |=>
    (byp_q == $past(byp_default)))
    else $error("Bypass bits not defaulted on software reset.");

  // Checks on the strap load, the read answer, the remaining counter and the carrier extension flag.
  // They watch outputs and also internal state such as byp_q, cnt_val and st_sc_q.
  strap_load_a: assert property (!strap_done_q |=>
    (byp_q[PSB_BY_CLOCK_OUTPUT_PIN] == $past(strap_s2_q)))
    else $error("Clock output enable not loaded from the strap.");

  rvalid_pulse_a: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("Read valid does not follow the read strobe.");

  rdata_hold_a: assert property (!reg_rd_i |=>
    $stable(reg_rdata_o))
    else $error("Read data changed without a read.");

  cnt_step_a: assert property ((cnt_inc[2] && !cnt_clr[2] && (cnt_val[2] != PSB_CNT_MAX)) |=>
    (cnt_val[2] == $past(cnt_val[2]) + 8'h01))
    else $error("Link drop counter did not count its event.");

  flag_ext_a: assert property (events_i.ext_err |=> st_sc_q[7])
    else $error("Carrier extension flag not set by event.");

endmodule

// ==== rtl/psb_sat_counter.sv ====
// Saturating 8-bit event counter that clears when software reads it.
// Assumes event and clear pulses on the same clock as the counter.
`timescale 1ns/100ps
module psb_sat_counter (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          inc_i,
  input  wire logic                          clr_i,
  output logic [psb_pkg::PSB_CNT_W-1:0]      count_o
);
  import psb_pkg::*;

  // Count register.
  logic [PSB_CNT_W-1:0] count_q;

  // A clearing read restarts the count and still keeps an event of that cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= PSB_CNT_RST;
    end else if (clr_i) begin
      count_q <= inc_i ? (PSB_CNT_RST + 8'h01) : PSB_CNT_RST;
    end else if (inc_i && (count_q != PSB_CNT_MAX)) begin
      count_q <= count_q + 8'h01;
    end
  end

  assign count_o = count_q;

endmodule

// ==== verification/psb_regs_bench.sv ====
// Self-checking bench for the status, bypass control and error counter registers.
// Assumes the package from include/ and the register block from rtl/ are compiled first.
`timescale 1ns/100ps
`define CHECK_EQ(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module psb_regs_bench;
  import psb_pkg::*;

  logic          clk       = 1'b0;     // Bench clock, 50 ns period.
  logic          rst_n     = 1'b0;     // Asynchronous reset, active low.
  logic [4:0]    addr      = 5'h00;    // Register address.
  logic          wr        = 1'b0;     // Write strobe.
  logic          rd        = 1'b0;     // Read strobe.
  logic [15:0]   wdata     = 16'h0000; // Write data.
  logic [15:0]   rdata;                // Read data from the block.
  logic          rvalid;               // Read answer strobe.
  logic          hit;                  // Address owned by the block.
  logic          soft_rst  = 1'b0;     // Software reset pulse.
  logic          sticky_en = 1'b1;     // Keep sticky bits on software reset.
  logic          strap     = 1'b1;     // Strap default for the clock output enable.
  psb_events_s   ev        = '0;       // Datapath levels and event pulses.
  psb_ctrl_s     ctrl;                 // Datapath controls from the block.
  int            err_count   = 0;      // Mismatches seen.
  int            checks_done = 0;      // Comparisons made.
  int            cycles      = 0;      // Cycle counter for the hang limit.
  logic [15:0]   d;                    // Last value read.
  logic [15:0]   v;                    // Value written to the bypass register.
  int            n;                    // Number of events to count.
  int            flag_bit [7] = '{14, 13, 11, 10, 9, 8, 7}; // Status bit of each flag.

  psb_regs i_dut (
    .clk_i               (clk),
    .rst_n_i             (rst_n),
    .reg_addr_i          (addr),
    .reg_wr_i            (wr),
    .reg_rd_i            (rd),
    .reg_wdata_i         (wdata),
    .reg_rdata_o         (rdata),
    .reg_rvalid_o        (rvalid),
    .reg_hit_o           (hit),
    .soft_reset_i        (soft_rst),
    .sticky_reset_en_i   (sticky_en),
    .config_strap_pins_i (strap),
    .events_i            (ev),
    .ctrl_o              (ctrl)
  );

  // The clock toggles every half period.
  always #25 clk = ~clk;

  // A run that hangs counts as a mismatch and ends in the closing report.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end

  // Controls mirror the bypass bits, with the reserved bit 8 left out.
  function automatic logic [14:0] exp_ctrl(input logic [15:0] r);
    return {r[15:9], r[7:0]};
  endfunction

  // Live status bits; the legacy partner bit is hidden while its detection is off.
  function automatic logic [15:0] exp_stat(input psb_events_s e, input logic legdis);
    logic [15:0] s;
    s     = 16'h0000;
    s[15] = e.descr_locked;
    s[12] = e.link_up;
    s[6]  = e.legacy_lp & ~legdis;
    s[5]  = e.xover_err;
    return s;
  endfunction

  // One write: strobe held for one rising edge, then released.
  task automatic reg_write(input logic [4:0] a, input logic [15:0] w);
    @(negedge clk);
    addr  = a;
    wdata = w;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
  endtask

  // One read: the answer is sampled half a cycle after the taking edge.
  task automatic reg_read(input logic [4:0] a, output logic [15:0] r);
    logic exp_hit;
    exp_hit = a inside {PSB_ADDR_STATUS, PSB_ADDR_BYPASS, PSB_ADDR_RXERR, PSB_ADDR_FCAR,
                        PSB_ADDR_LDROP};
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    `CHECK_EQ("read valid", 1'b1, rvalid)
    `CHECK_EQ("reg hit", exp_hit, hit)
    r = rdata;
  endtask

  // Holds one event field high for cnt rising edges.
  task automatic pulse(input int idx, input int cnt);
    @(negedge clk);
    ev[idx] = 1'b1;
    repeat (cnt) @(negedge clk);
    ev[idx] = 1'b0;
  endtask

  // Software reset pulse of one cycle.
  task automatic soft_reset();
    @(negedge clk);
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks done %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'hb923));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    // Reset values, with the strap held high through reset.
    reg_read(PSB_ADDR_BYPASS, d);
    `CHECK_EQ("bypass reset", 16'h0089, d)
    `CHECK_EQ("ctrl reset", exp_ctrl(16'h0089), ctrl)
    // Bypass writes, all ones first, then random; bit 8 never sticks.
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      reg_write(PSB_ADDR_BYPASS, v);
      `CHECK_EQ("ctrl after write", exp_ctrl(v & 16'hFEFF), ctrl)
      reg_read(PSB_ADDR_BYPASS, d);
      `CHECK_EQ("bypass readback", v & 16'hFEFF, d)
    end
    // Status levels with legacy detection on and off; a write to status is ignored.
    reg_write(PSB_ADDR_STATUS, 16'hFFFF);
    for (int i = 0; i < 6; i++) begin
      v = 16'h0088 | (16'(i % 2) << 6);
      reg_write(PSB_ADDR_BYPASS, v);
      @(negedge clk);
      ev[13:10] = 4'($urandom) | 4'b0010;
      reg_read(PSB_ADDR_STATUS, d);
      `CHECK_EQ("status levels", exp_stat(ev, v[6]), d)
    end
    ev = '0;
    // Each self-clearing flag is set by its event and cleared by the read.
    for (int i = 0; i < 7; i++) begin
      pulse(9 - i, 1);
      reg_read(PSB_ADDR_STATUS, d);
      `CHECK_EQ("flag set", 16'h0001 << flag_bit[i], d)
      reg_read(PSB_ADDR_STATUS, d);
      `CHECK_EQ("flag cleared", 16'h0000, d)
    end
    // Each counter counts its own events and clears on read.
    for (int c = 0; c < 3; c++) begin
      n = $urandom_range(1, 40);
      pulse(2 - c, n);
      reg_read(PSB_ADDR_RXERR + 5'(c), d);
      `CHECK_EQ("counter value", 16'(n), d)
      reg_read(PSB_ADDR_RXERR + 5'(c), d);
      `CHECK_EQ("counter cleared", 16'h0000, d)
    end
    // Saturation at the top of the count.
    pulse(2, 300);
    reg_read(PSB_ADDR_RXERR, d);
    `CHECK_EQ("counter saturated", 16'h00FF, d)
    // An event in the clearing read cycle survives as one count.
    pulse(1, 5);
    @(negedge clk);
    addr = PSB_ADDR_FCAR;
    rd   = 1'b1;
    ev.false_car_ev = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    ev.false_car_ev = 1'b0;
    `CHECK_EQ("count at read", 16'h0005, rdata)
    reg_read(PSB_ADDR_FCAR, d);
    `CHECK_EQ("count after clash", 16'h0001, d)
    // Software reset keeps sticky bits only while enabled.
    reg_write(PSB_ADDR_BYPASS, 16'hFFFF);
    sticky_en = 1'b1;
    soft_reset();
    reg_read(PSB_ADDR_BYPASS, d);
    `CHECK_EQ("sticky kept", 16'h00FB, d)
    reg_write(PSB_ADDR_BYPASS, 16'hFFFF);
    sticky_en = 1'b0;
    soft_reset();
    reg_read(PSB_ADDR_BYPASS, d);
    `CHECK_EQ("sticky default", 16'h0089, d)
    `CHECK_EQ("ctrl default", exp_ctrl(16'h0089), ctrl)
    // An unmapped place ignores writes and reads zero.
    reg_write(5'h16, 16'hFFFF);
    reg_read(5'h16, d);
    `CHECK_EQ("unmapped read", 16'h0000, d)
    stop_test();
  end
endmodule
